// file: usbhbc_top.sv
// host bus configuration, endpoint set and dma port control of the usb peripheral
// assumes an avalon-mm master on clk, mode pins and dma data pins asynchronous
//
// The implementer's own choices: register access over Avalon-MM and the register addresses.
`default_nettype none

module usbhbc_top (
  input  wire logic        clk,
  input  wire logic        nrst,
  input  wire logic [7:0]  address,
  input  wire logic        read,
  input  wire logic        write,
  input  wire logic [31:0] writedata,
  input  wire logic [3:0]  byteenable,
  output var  logic [31:0] readdata,
  output var  logic        waitrequest,
  input  wire logic        busConfigSelect,
  input  wire logic        strobeStyleSelect,
  input  wire logic        addressPhaseSelect,
  input  wire logic        linkHsDetected,
  input  wire logic [15:0] dmaDataIn,
  output var  logic [15:0] dmaDataOut,
  output var  logic        dmaDataOe,
  output var  logic        dmaReadStrobeN,
  output var  logic        dmaWriteStrobeN,
  output var  usbhbc_pkg::usbhbc_mode_s modeOut
);
  import usbhbc_pkg::*;

  logic [NUM_PINS-1:0] pinSync;
  logic [15:0]         dmaInSync;
  logic [31:0]         memRdata;
  logic                memWe;

  usbhbc_sync #(.WIDTH(NUM_PINS)) u_pin_sync (
    .clk  (clk),
    .nrst (nrst),
    .din  ({linkHsDetected, addressPhaseSelect, strobeStyleSelect, busConfigSelect}),
    .dout (pinSync)
  );

  usbhbc_sync #(.WIDTH(16)) u_dma_sync (
    .clk  (clk),
    .nrst (nrst),
    .din  (dmaDataIn),
    .dout (dmaInSync)
  );

  // ---------------- mode capture ----------------
  usbhbc_mode_s mode_ff;
  usbhbc_mode_s nxt_mode;
  logic         latched_ff;
  logic         nxt_latched;
  logic [1:0]   capCnt_ff;
  logic [1:0]   nxt_capCnt;

  // wait for the synchroniser to fill, then catch the straps once
  always_comb begin
    nxt_mode    = mode_ff;
    nxt_latched = latched_ff;
    nxt_capCnt  = capCnt_ff;
    if (!latched_ff) begin
      if (capCnt_ff == 2'h2) begin
        nxt_mode.generic    = pinSync[0];
        nxt_mode.sepStrobes = pinSync[1];
        nxt_mode.addrLine   = pinSync[2];
        nxt_latched         = 1'b1;
      end else begin
        nxt_capCnt = capCnt_ff + 2'h1;
      end
    end
    nxt_mode.highSpeed = pinSync[3];
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      mode_ff    <= '0;
      latched_ff <= 1'b0;
      capCnt_ff  <= 2'h0;
    end else begin
      mode_ff    <= nxt_mode;
      latched_ff <= nxt_latched;
      capCnt_ff  <= nxt_capCnt;
    end
  end

  // ---------------- register bus and endpoint state ----------------
  usbhbc_bus_e          state_ff;
  usbhbc_bus_e          nxt_state;
  logic [31:0]          rdData_ff;
  logic [31:0]          nxt_rdData;
  logic                 wait_ff;
  logic [NUM_CFG_EP-1:0] epEn_ff;
  logic [NUM_CFG_EP-1:0] nxt_epEn;
  logic [3:0]           epSel_ff;
  logic [3:0]           nxt_epSel;
  usbhbc_ep_cfg_s       epCfg_ff [NUM_CFG_EP];
  usbhbc_ep_cfg_s       nxt_epCfg [NUM_CFG_EP];
  logic [FIFO_AW-1:0]   fifoAddr_ff;
  logic [FIFO_AW-1:0]   nxt_fifoAddr;
  logic [15:0]          allocBytes_ff;
  logic [15:0]          nxt_allocBytes;
  logic [1:0]           dmaCtrl_ff;
  logic [1:0]           nxt_dmaCtrl;
  logic [15:0]          dmaWord_ff;
  logic [15:0]          nxt_dmaWord;
  logic                 dmaGo;
  logic                 dmaBusy_ff;
  logic                 dmaLive_ff;
  logic [15:0]          dmaRdWord_ff;
  logic [31:0]          rdMux;
  logic [3:0]           cfgIdx;
  logic                 selCfg;
  logic [7:0]           wordAddr;

  assign wordAddr = {address[7:2], 2'h0};
  assign selCfg   = (epSel_ff >= CFG_EP_BASE);
  assign cfgIdx   = 4'(epSel_ff - CFG_EP_BASE);
  assign memWe    = (state_ff == ST_ACK) && write && (wordAddr == REG_FIFO_DATA);
  assign dmaGo    = (state_ff == ST_ACK) && write && (wordAddr == REG_DMA_CMD);

  // read mux; control endpoints report their fixed layout
  always_comb begin
    rdMux = '0;
    case (wordAddr)
      REG_MODE: begin
        rdMux[MODE_GENERIC_BIT] = mode_ff.generic;
        rdMux[MODE_SEPSTB_BIT]  = mode_ff.sepStrobes;
        rdMux[MODE_ADDRL_BIT]   = mode_ff.addrLine;
        rdMux[MODE_HS_BIT]      = mode_ff.highSpeed;
        rdMux[MODE_DMALIVE_BIT] = dmaLive_ff;
        rdMux[MODE_LATCHED_BIT] = latched_ff;
      end
      REG_EP_EN:  rdMux[NUM_CFG_EP-1:0] = epEn_ff;
      REG_EP_SEL: rdMux[3:0] = epSel_ff;
      REG_EP_CFG: rdMux[13:0] = selCfg ? epCfg_ff[cfgIdx] : EP_CFG_CTRL;
      REG_ALLOC: begin
        rdMux[15:0] = allocBytes_ff;
        rdMux[ALLOC_OVER_BIT] = (allocBytes_ff > FIFO_BYTES);
      end
      REG_DMA_CTRL: begin
        rdMux[1:0] = dmaCtrl_ff;
        rdMux[DMA_BUSY_BIT] = dmaBusy_ff;
      end
      REG_DMA_CMD:   rdMux[15:0] = dmaRdWord_ff;
      REG_FIFO_ADDR: rdMux[FIFO_AW-1:0] = fifoAddr_ff;
      default:       rdMux = '0;
    endcase
  end

  // bus handshake plus register writes, committed in the acknowledge cycle
  always_comb begin
    nxt_state    = state_ff;
    nxt_rdData   = rdData_ff;
    nxt_epEn     = epEn_ff;
    nxt_epSel    = epSel_ff;
    nxt_epCfg    = epCfg_ff;
    nxt_fifoAddr = fifoAddr_ff;
    nxt_dmaCtrl  = dmaCtrl_ff;
    nxt_dmaWord  = dmaWord_ff;
    case (state_ff)
      ST_IDLE: begin
        if (read && (wordAddr == REG_FIFO_DATA)) begin
          nxt_state = ST_MEMRD;
        end else if (read || write) begin
          nxt_rdData = rdMux;
          nxt_state  = ST_ACK;
        end
      end
      ST_MEMRD: begin
        nxt_rdData = memRdata;
        nxt_state  = ST_ACK;
      end
      ST_ACK: begin
        nxt_state = ST_IDLE;
        if (wordAddr == REG_FIFO_DATA) begin
          nxt_fifoAddr = fifoAddr_ff + 11'h001;
        end
        if (write) begin
          case (wordAddr)
            REG_EP_EN:  nxt_epEn = writedata[NUM_CFG_EP-1:0];
            REG_EP_SEL: nxt_epSel = writedata[3:0];
            REG_EP_CFG: begin
              if (selCfg) begin
                nxt_epCfg[cfgIdx] = writedata[13:0];
              end
            end
            REG_DMA_CTRL: begin
              nxt_dmaCtrl = writedata[1:0];
              nxt_dmaCtrl[DMA_MASTER_BIT] = writedata[DMA_MASTER_BIT] && !mode_ff.generic;
            end
            REG_DMA_CMD:   nxt_dmaWord = writedata[15:0];
            REG_FIFO_ADDR: nxt_fifoAddr = writedata[FIFO_AW-1:0];
            default:       nxt_state = ST_IDLE;
          endcase
        end
      end
      default: nxt_state = ST_IDLE;
    endcase
  end

  // fifo budget: setup plus both control endpoints, then enabled data endpoints
  always_comb begin
    nxt_allocBytes = ALLOC_FIXED;
    for (int i = 0; i < NUM_CFG_EP; i++) begin
      if (epEn_ff[i]) begin
        nxt_allocBytes = nxt_allocBytes + (epCfg_ff[i].dblBuf ?
          {4'h0, epCfg_ff[i].maxPkt, 1'b0} : {5'h0, epCfg_ff[i].maxPkt});
      end
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_ff      <= ST_IDLE;
      rdData_ff     <= '0;
      wait_ff       <= 1'b1;
      epEn_ff       <= '0;
      epSel_ff      <= '0;
      fifoAddr_ff   <= '0;
      allocBytes_ff <= ALLOC_FIXED;
      dmaCtrl_ff    <= '0;
      dmaWord_ff    <= '0;
      for (int i = 0; i < NUM_CFG_EP; i++) begin
        epCfg_ff[i] <= EP_CFG_RST;
      end
    end else begin
      state_ff      <= nxt_state;
      rdData_ff     <= nxt_rdData;
      wait_ff       <= (nxt_state != ST_ACK);
      epEn_ff       <= nxt_epEn;
      epSel_ff      <= nxt_epSel;
      epCfg_ff      <= nxt_epCfg;
      fifoAddr_ff   <= nxt_fifoAddr;
      allocBytes_ff <= nxt_allocBytes;
      dmaCtrl_ff    <= nxt_dmaCtrl;
      dmaWord_ff    <= nxt_dmaWord;
    end
  end

  usbhbc_fifo_mem u_fifo_mem (
    .clk   (clk),
    .we    (memWe),
    .be    (byteenable),
    .addr  (fifoAddr_ff),
    .wdata (writedata),
    .rdata (memRdata)
  );

  // ---------------- dma port ----------------
  logic       nxt_dmaLive;
  logic       nxt_dmaBusy;
  logic [1:0] stbCnt_ff;
  logic [1:0] nxt_stbCnt;
  logic       rdStbN_ff;
  logic       nxt_rdStbN;
  logic       wrStbN_ff;
  logic       nxt_wrStbN;
  logic [15:0] nxt_dmaRdWord;
  logic        dmaOe_ff;
  logic        nxt_dmaOe;
  logic [1:0]  capPipe_ff;
  logic [1:0]  nxt_capPipe;

  // strobes only pulse as master; as slave the external party strobes
  always_comb begin
    nxt_dmaLive   = dmaLive_ff;
    nxt_dmaBusy   = dmaBusy_ff;
    nxt_stbCnt    = stbCnt_ff;
    nxt_rdStbN    = 1'b1;
    nxt_wrStbN    = 1'b1;
    nxt_dmaRdWord = dmaRdWord_ff;
    nxt_capPipe   = {capPipe_ff[0], 1'b0};
    // word taken two cycles after the strobe, once the synchroniser holds strobed data
    if (capPipe_ff[1]) begin
      nxt_dmaRdWord = dmaInSync;
    end
    if (dmaGo) begin
      nxt_dmaLive = 1'b1;
      if (dmaCtrl_ff[DMA_MASTER_BIT]) begin
        nxt_dmaBusy = 1'b1;
        nxt_stbCnt  = STB_CYC;
      end
    end else if (dmaBusy_ff) begin
      if (stbCnt_ff == 2'h0) begin
        nxt_dmaBusy    = 1'b0; // busy drops before the read word lands
        nxt_capPipe[0] = !dmaCtrl_ff[DMA_DIROUT_BIT];
      end else begin
        nxt_stbCnt = stbCnt_ff - 2'h1;
        nxt_rdStbN = dmaCtrl_ff[DMA_DIROUT_BIT];
        nxt_wrStbN = !dmaCtrl_ff[DMA_DIROUT_BIT];
      end
    end
    // enable registered so the pin comes straight from a flop
    nxt_dmaOe = nxt_dmaLive && nxt_dmaCtrl[DMA_DIROUT_BIT];
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      dmaLive_ff   <= 1'b0;
      dmaBusy_ff   <= 1'b0;
      stbCnt_ff    <= 2'h0;
      rdStbN_ff    <= 1'b1;
      wrStbN_ff    <= 1'b1;
      dmaRdWord_ff <= '0;
      dmaOe_ff     <= 1'b0;
      capPipe_ff   <= 2'h0;
    end else begin
      dmaLive_ff   <= nxt_dmaLive;
      dmaBusy_ff   <= nxt_dmaBusy;
      stbCnt_ff    <= nxt_stbCnt;
      rdStbN_ff    <= nxt_rdStbN;
      wrStbN_ff    <= nxt_wrStbN;
      dmaRdWord_ff <= nxt_dmaRdWord;
      dmaOe_ff     <= nxt_dmaOe;
      capPipe_ff   <= nxt_capPipe;
    end
  end

  // outputs straight from flops; strobes have no enable and are never floated
  assign readdata        = rdData_ff;
  assign waitrequest     = wait_ff;
  assign dmaDataOut      = dmaWord_ff;
  assign dmaDataOe       = dmaOe_ff;
  assign dmaReadStrobeN  = rdStbN_ff;
  assign dmaWriteStrobeN = wrStbN_ff;
  assign modeOut         = mode_ff;

  // ---------------- checks ----------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  a_dma_bus_float: assert property (!dmaLive_ff |-> !dmaDataOe)
    else $error("dma bus driven before first dma command");
  a_strobe_idle: assert property (!dmaBusy_ff |=> dmaReadStrobeN && dmaWriteStrobeN)
    else $error("dma strobe active outside a master transfer");
  a_mode_capture: assert property ((!latched_ff && capCnt_ff == 2'h2)
    |=> latched_ff && modeOut.generic == $past(pinSync[0]))
    else $error("bus configuration not captured from pin");
  a_generic_slave: assert property (modeOut.generic && latched_ff
    |=> !dmaCtrl_ff[DMA_MASTER_BIT] || $past(dmaCtrl_ff[DMA_MASTER_BIT]))
    else $error("dma master enabled in generic mode");
  a_ctrl_fixed: assert property ((state_ff == ST_IDLE) && read && (wordAddr == REG_EP_CFG)
    && !selCfg |=> readdata[10:0] == CTRL_PKT && !readdata[11])
    else $error("control endpoint layout not fixed");
  a_alloc_floor: assert property (allocBytes_ff >= ALLOC_FIXED)
    else $error("fifo budget below fixed endpoints");
  a_mode_hold: assert property (latched_ff |=> $stable(modeOut.generic)
    && $stable(modeOut.sepStrobes) && $stable(modeOut.addrLine))
    else $error("latched mode changed");
  a_speed_follow: assert property ($changed(pinSync[3]) |=> modeOut.highSpeed == $past(pinSync[3]))
    else $error("link speed not tracked");
  a_ack_single: assert property (!waitrequest |=> waitrequest)
    else $error("acknowledge lasted more than one cycle");
  a_strobe_width: assert property ($fell(dmaWriteStrobeN) |-> !dmaWriteStrobeN [*2] ##1 dmaWriteStrobeN)
    else $error("write strobe width wrong");

  c_fifo_read:  cover property ((state_ff == ST_MEMRD) ##1 !waitrequest);
  c_dma_master: cover property ($fell(dmaReadStrobeN));
  c_split_mode: cover property (latched_ff && !modeOut.generic);
  c_dma_live:   cover property ($rose(dmaDataOe));

endmodule

`default_nettype wire

// file: usbhbc_pkg.sv
// constants, field layouts and carrier types for the usb host bus configuration block
// assumes one 100 MHz clock and an avalon-mm register bus with byte addresses
//
// Summary of operation
// - dma data bus stays undriven from reset until the first dma command runs.
// - control outputs such as dma strobes are always actively driven, never floated.
// - bus config pin sampled at power-up; high generic processor, low split bus.
// - generic mode: 8-bit bus carries register address, 16-bit bus carries data and dma.
// - generic mode: dma port is slave only, on shared data bus with dma strobes.
// - split mode: 8-bit bus multiplexes address and data, 16-bit bus is dma only.
// - split mode: second select pin picks address latch strobe or single address line.
// - split mode: dma port may act as master or slave on its own data bus.
// - first select pin at power-up: low direction plus data strobe, high separate strobes.
// - up to 16 endpoints: control in, control out, seven in, seven out, plus setup.
// - 8 kB fifo shared by enabled endpoints, control endpoints and setup buffer.
// - both control endpoints fixed at 64 bytes, never double buffered.
// - setup tokens land in a separate fixed 8-byte buffer, not double buffered.
// - each of fourteen data endpoints is enabled or disabled on its own.
// - each data endpoint takes its own transfer type and maximum packet size.
// - each data endpoint may be double buffered, giving two packet buffers.
// - link speed, high or full, is detected with no firmware choice.
// - signals with the active-low suffix are asserted when low.
`default_nettype none

package usbhbc_pkg;

  // register byte offsets
  localparam logic [7:0] REG_MODE      = 8'h00;
  localparam logic [7:0] REG_EP_EN     = 8'h04;
  localparam logic [7:0] REG_EP_SEL    = 8'h08;
  localparam logic [7:0] REG_EP_CFG    = 8'h0c;
  localparam logic [7:0] REG_ALLOC     = 8'h10;
  localparam logic [7:0] REG_DMA_CTRL  = 8'h14;
  localparam logic [7:0] REG_DMA_CMD   = 8'h18;
  localparam logic [7:0] REG_FIFO_ADDR = 8'h1c;
  localparam logic [7:0] REG_FIFO_DATA = 8'h20;

  // endpoint set and storage
  localparam int          NUM_EP      = 16;
  localparam int          NUM_CFG_EP  = 14;
  localparam logic [3:0]  CFG_EP_BASE = 4'h2;
  localparam logic [10:0] CTRL_PKT    = 11'h040;
  localparam logic [15:0] SETUP_BYTES = 16'h0008;
  localparam logic [15:0] FIFO_BYTES  = 16'h2000;
  localparam int          FIFO_AW     = 11;
  localparam logic [15:0] ALLOC_FIXED = 16'(SETUP_BYTES + 16'(CTRL_PKT) + 16'(CTRL_PKT));

  // mode, dma control and alloc register fields, pin count
  localparam int MODE_GENERIC_BIT = 0;
  localparam int MODE_SEPSTB_BIT  = 1;
  localparam int MODE_ADDRL_BIT   = 2;
  localparam int MODE_HS_BIT      = 3;
  localparam int MODE_DMALIVE_BIT = 4;
  localparam int MODE_LATCHED_BIT = 5;
  localparam int DMA_MASTER_BIT   = 0;
  localparam int DMA_DIROUT_BIT   = 1;
  localparam int DMA_BUSY_BIT     = 2;
  localparam int ALLOC_OVER_BIT   = 31;
  localparam int NUM_PINS         = 4;

  // timing
  localparam int CLK_NS         = 10;
  localparam int DMA_STROBE_NS  = 20;
  localparam int DMA_STROBE_CYC = (DMA_STROBE_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [1:0] STB_CYC = 2'(DMA_STROBE_CYC);

  typedef enum logic [1:0] {
    XFER_INT  = 2'h0,
    XFER_ISO  = 2'h1,
    XFER_BULK = 2'h2,
    XFER_CTRL = 2'h3
  } usbhbc_xfer_e;

  typedef struct packed {
    usbhbc_xfer_e xferType;
    logic         dblBuf;
    logic [10:0]  maxPkt;
  } usbhbc_ep_cfg_s;

  localparam usbhbc_ep_cfg_s EP_CFG_RST = '{XFER_BULK, 1'b0, 11'h040};
  localparam usbhbc_ep_cfg_s EP_CFG_CTRL = '{XFER_CTRL, 1'b0, 11'h040};

  typedef struct packed {
    logic generic;
    logic sepStrobes;
    logic addrLine;
    logic highSpeed;
  } usbhbc_mode_s;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'h0,
    ST_MEMRD = 2'h1,
    ST_ACK   = 2'h3
  } usbhbc_bus_e;

endpackage

`default_nettype wire

// file: usbhbc_sync.sv
// two-flop synchroniser for a group of pin inputs
// assumes the inputs are asynchronous to clk; only the second stage is read
`default_nettype none

module usbhbc_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk,
  input  wire logic             nrst,
  input  wire logic [WIDTH-1:0] din,
  output var  logic [WIDTH-1:0] dout
);

  logic [WIDTH-1:0] meta_ff;

  // first stage feeds only the second
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      meta_ff <= '0;
      dout    <= '0;
    end else begin
      meta_ff <= din;
      dout    <= meta_ff;
    end
  end

endmodule

`default_nettype wire

// file: usbhbc_fifo_mem.sv
// shared endpoint fifo storage, 8 kB as 32-bit words with byte write enables
// assumes one access per cycle; read data are registered, one cycle late
`default_nettype none

module usbhbc_fifo_mem (
  input  wire logic                             clk,
  input  wire logic                             we,
  input  wire logic [3:0]                       be,
  input  wire logic [usbhbc_pkg::FIFO_AW-1:0]   addr,
  input  wire logic [31:0]                      wdata,
  output var  logic [31:0]                      rdata
);
  import usbhbc_pkg::*;

  logic [31:0] mem [2**FIFO_AW];

  // no reset on the array, so it maps onto block ram
  always_ff @(posedge clk) begin
    for (int b = 0; b < 4; b++) begin
      if (we && be[b]) begin
        mem[addr][b*8 +: 8] <= wdata[b*8 +: 8];
      end
    end
    rdata <= mem[addr];
  end

endmodule

`default_nettype wire

// file: usbhbc_dma_peer.sv
// dma peripheral model on the far side of the dma port
// assumes active-low strobes from the device and a 16-bit dma data bus
`default_nettype none

module usbhbc_dma_peer #(
  parameter logic [15:0] WORD = 16'hc3a5,
  parameter int          HOLD = 2
) (
  input  wire logic        clk,
  input  wire logic        readStrobeN,
  input  wire logic        writeStrobeN,
  input  wire logic [15:0] busIn,
  input  wire logic        busOe,
  output var  logic [15:0] busOut,
  output var  logic [15:0] lastWritten
);
  timeunit 1ns;
  timeprecision 100ps;

  logic [15:0] noise = 16'h5a5a;
  int          hold  = 0;

  // data held a short time after the strobe rises, then the bus floats
  always @(posedge clk) begin
    noise <= ~noise;
    hold  <= !readStrobeN ? HOLD : (hold > 0 ? hold - 1 : 0);
  end

  // a floating bus shows a pattern that changes, never the last word
  assign busOut = (!readStrobeN || hold > 0) ? WORD : noise;

  // word taken as the write strobe is released, spoiled if not driven
  always @(posedge writeStrobeN) begin
    lastWritten <= busOe ? busIn : ~busIn;
  end
endmodule

`default_nettype wire

// file: usb_peripheral_host_bus_config_tb_top.sv
// self-checking bench for the host bus configuration block
// assumes the package is compiled first and the dma peer model is present
`default_nettype none

module usb_peripheral_host_bus_config_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  import usbhbc_pkg::*;

  localparam logic [15:0] PEER_WORD = 16'hc3a5;

  logic         clk        = 1'b0;
  logic         nrst       = 1'b0;
  logic [7:0]   address    = 8'h00;
  logic         read       = 1'b0;
  logic         write      = 1'b0;
  logic [31:0]  writedata  = 32'h0;
  logic [3:0]   byteenable = 4'hf;
  logic         busCfg     = 1'b1;
  logic         stbStyle   = 1'b1;
  logic         addrPhase  = 1'b0;
  logic         linkHs     = 1'b0;
  logic [31:0]  readdata;
  logic         waitrequest;
  logic [15:0]  dmaIn;
  logic [15:0]  dmaOut;
  logic [15:0]  lastWritten;
  logic         dmaOe;
  logic         rdStbN;
  logic         wrStbN;
  usbhbc_mode_s modeOut;
  logic [31:0]  rd;
  logic [31:0]  sum;
  int           miscompares = 0;
  int           n_tests     = 0;
  int           rdLow       = 0;
  int           wrLow       = 0;

  always #5 clk = ~clk;

  usbhbc_top dut (
    .clk(clk), .nrst(nrst), .address(address), .read(read), .write(write),
    .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
    .waitrequest(waitrequest), .busConfigSelect(busCfg), .strobeStyleSelect(stbStyle),
    .addressPhaseSelect(addrPhase), .linkHsDetected(linkHs), .dmaDataIn(dmaIn),
    .dmaDataOut(dmaOut), .dmaDataOe(dmaOe), .dmaReadStrobeN(rdStbN),
    .dmaWriteStrobeN(wrStbN), .modeOut(modeOut)
  );

  usbhbc_dma_peer #(.WORD(PEER_WORD), .HOLD(2)) peer (
    .clk(clk), .readStrobeN(rdStbN), .writeStrobeN(wrStbN), .busIn(dmaOut),
    .busOe(dmaOe), .busOut(dmaIn), .lastWritten(lastWritten)
  );

  // strobe low time in cycles, cleared by the test before each command
  always @(posedge clk) begin
    if (rdStbN === 1'b0) rdLow <= rdLow + 1;
    if (wrStbN === 1'b0) wrLow <= wrLow + 1;
  end

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  // one avalon access, held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    address   <= a;
    writedata <= d;
    write     <= wr;
    read      <= !wr;
    do begin
      @(posedge clk);
      n++;
    end while (waitrequest !== 1'b0 && n < 20);
    if (n >= 20) chk("bus answer", 32'h0, 32'h1);
    rd = readdata;
    write <= 1'b0;
    read  <= 1'b0;
  endtask

  task automatic rdchk(input string what, input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk(what, exp, rd);
  endtask

  // straps are set as reset is asserted so they are stable well ahead of capture
  task automatic do_reset(input logic bc, input logic ss, input logic ap);
    nrst      <= 1'b0;
    busCfg    <= bc;
    stbStyle  <= ss;
    addrPhase <= ap;
    repeat (12) @(posedge clk);
    chk("oe in reset", 32'h0, 32'(dmaOe));
    chk("strobes in reset", 32'h3, {30'h0, rdStbN, wrStbN});
    nrst <= 1'b1;
    repeat (6) @(posedge clk);
  endtask

  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  initial begin
    // generic bus with separate strobes, link at full speed
    do_reset(1'b1, 1'b1, 1'b0);
    rdchk("mode", REG_MODE, 32'h23);
    chk("mode pins", 32'h0c, 32'(modeOut));
    busCfg    <= 1'b0;
    stbStyle  <= 1'b0;
    addrPhase <= 1'b1;
    linkHs    <= 1'b1;
    repeat (6) @(posedge clk);
    rdchk("mode held", REG_MODE, 32'h2b);
    bus(1'b1, 8'h40, 32'hffff_ffff);
    rdchk("unmapped", 8'h40, 32'h0);
    // fixed endpoints: setup plus two control buffers, writes refused
    bus(1'b1, REG_EP_EN, 32'h0);
    rdchk("alloc fixed", REG_ALLOC, 32'h88);
    for (int i = 0; i < 2; i++) begin
      bus(1'b1, REG_EP_SEL, 32'(i));
      bus(1'b1, REG_EP_CFG, 32'h1123);
      rdchk("control ep cfg", REG_EP_CFG, 32'h3040);
    end
    // every data endpoint with its own type, size and buffering
    sum = 32'h88;
    for (int i = 2; i < 16; i++) begin
      bus(1'b1, REG_EP_SEL, 32'(i));
      bus(1'b1, REG_EP_CFG, {18'h0, 2'(i % 3), i[0], 11'(i * 16)});
      rdchk("data ep cfg", REG_EP_CFG, {18'h0, 2'(i % 3), i[0], 11'(i * 16)});
      sum += 32'((i[0] ? 32 : 16) * i);
    end
    bus(1'b1, REG_EP_EN, 32'h2a55);
    rdchk("ep enable", REG_EP_EN, 32'h2a55);
    bus(1'b1, REG_EP_EN, 32'h3fff);
    rdchk("alloc all", REG_ALLOC, sum);
    for (int i = 2; i < 16; i++) begin
      bus(1'b1, REG_EP_SEL, 32'(i));
      bus(1'b1, REG_EP_CFG, 32'h0c00);
    end
    rdchk("alloc over", REG_ALLOC, 32'h8000_7088);
    // last two words of the fifo, address steps by itself
    bus(1'b1, REG_FIFO_ADDR, 32'h7fe);
    for (int i = 0; i < 2; i++) begin
      bus(1'b1, REG_FIFO_DATA, 32'h1234_0000 + 32'(i));
    end
    bus(1'b1, REG_FIFO_ADDR, 32'h7fe);
    for (int i = 0; i < 2; i++) begin
      rdchk("fifo word", REG_FIFO_DATA, 32'h1234_0000 + 32'(i));
    end
    // generic mode: slave only, bus floats until the first command
    rdLow = 0;
    wrLow = 0;
    bus(1'b1, REG_DMA_CTRL, 32'h3);
    rdchk("dma ctrl slave", REG_DMA_CTRL, 32'h2);
    chk("oe before cmd", 32'h0, 32'(dmaOe));
    bus(1'b1, REG_DMA_CMD, 32'ha5c3);
    repeat (8) @(posedge clk);
    chk("slave strobes", 32'h0, 32'(rdLow + wrLow));
    chk("oe after cmd", 32'h1, 32'(dmaOe));
    chk("dma word out", 32'ha5c3, 32'(dmaOut));
    // split bus with address line, then master read and write
    do_reset(1'b0, 1'b0, 1'b1);
    rdchk("mode split", REG_MODE, 32'h2c);
    chk("mode pins split", 32'h3, 32'(modeOut));
    rdLow = 0;
    bus(1'b1, REG_DMA_CTRL, 32'h1);
    bus(1'b1, REG_DMA_CMD, 32'h0);
    repeat (8) @(posedge clk);
    chk("read strobe width", 32'(STB_CYC), 32'(rdLow));
    chk("oe on read", 32'h0, 32'(dmaOe));
    rdchk("dma word in", REG_DMA_CMD, {16'h0, PEER_WORD});
    wrLow = 0;
    bus(1'b1, REG_DMA_CTRL, 32'h3);
    rdchk("dma ctrl master", REG_DMA_CTRL, 32'h3);
    bus(1'b1, REG_DMA_CMD, 32'h3c5a);
    repeat (8) @(posedge clk);
    chk("write strobe width", 32'(STB_CYC), 32'(wrLow));
    chk("peer word", 32'h3c5a, {16'h0, lastWritten});
    end_sim;
  end

  // about 400 cycles of traffic expected; cut a hang well beyond that
  initial begin
    repeat (20000) @(posedge clk);
    miscompares++;
    end_sim;
  end
endmodule

`default_nettype wire
